//--- hdl/dsg_pkg.sv
// Purpose: Shared constants and types of the deep-sleep clock gating block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte address
// Notes: Gate registers share one bit layout
package dsg_pkg;
  // ==========================================================
  // Register map
  localparam int DSG_ADDR_W = 12;
  localparam logic [11:0] DSG_RCFG_OFF = 12'h060;
  localparam logic [11:0] DSG_RUN_OFF = 12'h104;
  localparam logic [11:0] DSG_SLP_OFF = 12'h114;
  localparam logic [11:0] DSG_DEEP_OFF = 12'h124;
  localparam logic [11:0] DSG_ISTAT_OFF = 12'h200;
  localparam logic [11:0] DSG_IMASK_OFF = 12'h204;
  localparam logic [11:0] DSG_PSTAT_OFF = 12'h208;
  // ==========================================================
  // Reset values and field layout
  localparam logic [31:0] DSG_GATE_RST = 32'h0000_0000;
  localparam logic [31:0] DSG_RCFG_RST = 32'h0000_0000;
  localparam logic [31:0] DSG_GATE_WMASK = 32'h0007_5031;
  localparam int DSG_ACG_BIT = 27;
  localparam int DSG_ASYNC0_POS = 0;
  localparam int DSG_SYNC0_POS = 4;
  localparam int DSG_SYNC1_POS = 5;
  localparam int DSG_TWO_WIRE0_POS = 12;
  localparam int DSG_TWO_WIRE1_POS = 14;
  localparam int DSG_GPC0_POS = 16;
  localparam int DSG_GPC1_POS = 17;
  localparam int DSG_GPC2_POS = 18;
  localparam int DSG_UNITS = 8;
  localparam int DSG_GATE_POS [DSG_UNITS] = '{DSG_ASYNC0_POS, DSG_SYNC0_POS,
    DSG_SYNC1_POS, DSG_TWO_WIRE0_POS, DSG_TWO_WIRE1_POS, DSG_GPC0_POS,
    DSG_GPC1_POS, DSG_GPC2_POS};
  // Interrupt status bits and bus response codes
  localparam int DSG_IRQ_W = 2;
  localparam int DSG_IRQ_FAULT = 0;
  localparam int DSG_IRQ_DEEP = 1;
  localparam logic [1:0] DSG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSG_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {DSG_RUN, DSG_SLEEP, DSG_DEEP} dsg_mode_t;
  typedef struct packed {
    logic valid;
    logic [DSG_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } dsg_wreq_t;
  typedef struct packed {
    logic valid;
    logic [DSG_ADDR_W-1:0] addr;
  } dsg_rreq_t;
  typedef struct packed {
    logic err;
    logic [31:0] data;
  } dsg_rresp_t;
endpackage

//--- hdl/dsg_gate_select.sv
// Purpose: Picks the gate set that applies in the present power mode
// Assumes: Mode and gate vectors come from flip-flops
// Notes: One cycle from inputs to clk_en
`timescale 1ns/1ps
module dsg_gate_select #(
  parameter int UNITS = 8
) (
  input logic aclk,
  input logic aresetn,
  input dsg_pkg::dsg_mode_t mode,
  input logic auto_clock_gating_select,
  input logic [UNITS-1:0] run_en,
  input logic [UNITS-1:0] sleep_en,
  input logic [UNITS-1:0] deep_en,
  output logic [UNITS-1:0] clk_en
);
  typedef struct packed {
    logic [UNITS-1:0] en;
  } dsg_sel_state_t;
  dsg_sel_state_t s;
  dsg_sel_state_t next_s;
  logic [UNITS-1:0] pick;

  // ==========================================================
  // Per-unit selection
  for (genvar i = 0; i < UNITS; i++) begin : g_unit
    // Without auto gating the run set rules in every mode
    assign pick[i] = !auto_clock_gating_select ? run_en[i] :
      (mode == dsg_pkg::DSG_DEEP) ? deep_en[i] :
      (mode == dsg_pkg::DSG_SLEEP) ? sleep_en[i] : run_en[i];
  end

  always_comb begin
    next_s = s;
    next_s.en = pick;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk_en = s.en;
endmodule

//--- hdl/dsg_axil_slave.sv
// Purpose: AXI4-Lite slave turning bus beats into register requests
// Assumes: One write and one read in flight at most
// Notes: Write answer two edges after both beats are held
`timescale 1ns/1ps
module dsg_axil_slave (
  input logic aclk,
  input logic aresetn,
  input logic [dsg_pkg::DSG_ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [dsg_pkg::DSG_ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  output dsg_pkg::dsg_wreq_t wreq,
  output dsg_pkg::dsg_rreq_t rreq,
  input logic werr,
  input dsg_pkg::dsg_rresp_t rans
);
  typedef struct packed {
    logic aw_full;
    logic w_full;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    dsg_pkg::dsg_wreq_t wreq;
    dsg_pkg::dsg_rreq_t rreq;
  } dsg_slv_state_t;
  dsg_slv_state_t s;
  dsg_slv_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.wreq.valid = 1'b0;
    next_s.rreq.valid = 1'b0;
    // ==========================================================
    // Write path: address and data may come in either order
    if (awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.wreq.addr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wreq.data = wdata;
      next_s.wreq.strb = wstrb;
    end
    if (s.aw_full && s.w_full && !s.wreq.valid && !s.bvalid) begin
      next_s.wreq.valid = 1'b1;
    end
    if (s.wreq.valid) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = werr ? dsg_pkg::DSG_RESP_SLVERR : dsg_pkg::DSG_RESP_OKAY;
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    // ==========================================================
    // Read path
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rreq.valid = 1'b1;
      next_s.rreq.addr = araddr;
    end
    if (s.rreq.valid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rans.data;
      next_s.rresp = rans.err ? dsg_pkg::DSG_RESP_SLVERR :
        dsg_pkg::DSG_RESP_OKAY;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign wreq = s.wreq;
  assign rreq = s.rreq;
endmodule

//--- hdl/dsg_top.sv
// Purpose: Per-unit clock enables with run, sleep and deep-sleep sets
// Assumes: Power mode inputs and unit access port synchronous to aclk
// Notes: Unit enables follow register changes after one extra edge
`timescale 1ns/1ps
module dsg_top #(
  parameter int UNITS = dsg_pkg::DSG_UNITS
) (
  input logic aclk,
  input logic aresetn,
  input logic [dsg_pkg::DSG_ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [dsg_pkg::DSG_ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic sleep_now,
  input logic deep_sleep_now,
  input logic unit_req,
  input logic [2:0] unit_sel,
  output logic unit_grant,
  output logic unit_fault,
  output logic [UNITS-1:0] unit_clk_en,
  output logic irq
);
  typedef struct packed {
    logic [31:0] run_gates;
    logic [31:0] sleep_gates;
    logic [31:0] deep_gates;
    logic [31:0] rcfg;
    logic [dsg_pkg::DSG_IRQ_W-1:0] istat;
    logic [dsg_pkg::DSG_IRQ_W-1:0] imask;
    dsg_pkg::dsg_mode_t mode;
    logic grant;
    logic fault;
    logic irq;
  } dsg_top_state_t;
  dsg_top_state_t s;
  dsg_top_state_t next_s;

  dsg_pkg::dsg_wreq_t wreq;
  dsg_pkg::dsg_rreq_t rreq;
  dsg_pkg::dsg_rresp_t rans;
  logic werr;
  logic auto_clock_gating_select;
  logic [UNITS-1:0] run_vec;
  logic [UNITS-1:0] sleep_vec;
  logic [UNITS-1:0] deep_vec;
  logic [UNITS-1:0] en_now;

  // ==========================================================
  // Register bus
  dsg_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wreq(wreq),
    .rreq(rreq),
    .werr(werr),
    .rans(rans)
  );

  // ==========================================================
  // Gate bit to unit mapping
  for (genvar i = 0; i < UNITS; i++) begin : g_map
    assign run_vec[i] = s.run_gates[dsg_pkg::DSG_GATE_POS[i]];
    assign sleep_vec[i] = s.sleep_gates[dsg_pkg::DSG_GATE_POS[i]];
    assign deep_vec[i] = s.deep_gates[dsg_pkg::DSG_GATE_POS[i]];
  end
  assign auto_clock_gating_select = s.rcfg[dsg_pkg::DSG_ACG_BIT];

  dsg_gate_select #(
    .UNITS(UNITS)
  ) u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(s.mode),
    .auto_clock_gating_select(auto_clock_gating_select),
    .run_en(run_vec),
    .sleep_en(sleep_vec),
    .deep_en(deep_vec),
    .clk_en(en_now)
  );

  // ==========================================================
  // Byte-lane merge
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Read decode
  always_comb begin
    rans.err = 1'b0;
    rans.data = 32'h0000_0000;
    if (rreq.addr == dsg_pkg::DSG_RUN_OFF) begin
      rans.data = s.run_gates;
    end else if (rreq.addr == dsg_pkg::DSG_SLP_OFF) begin
      rans.data = s.sleep_gates;
    end else if (rreq.addr == dsg_pkg::DSG_DEEP_OFF) begin
      rans.data = s.deep_gates;
    end else if (rreq.addr == dsg_pkg::DSG_RCFG_OFF) begin
      rans.data = s.rcfg;
    end else if (rreq.addr == dsg_pkg::DSG_ISTAT_OFF) begin
      rans.data = {30'h0000_0000, s.istat};
    end else if (rreq.addr == dsg_pkg::DSG_IMASK_OFF) begin
      rans.data = {30'h0000_0000, s.imask};
    end else if (rreq.addr == dsg_pkg::DSG_PSTAT_OFF) begin
      rans.data = {22'h00_0000, s.mode, en_now};
    end else begin
      rans.err = 1'b1;
    end
  end

  // Write address check; power status register is the only read-only one
  always_comb begin
    werr = 1'b1;
    if (wreq.addr == dsg_pkg::DSG_RUN_OFF) begin
      werr = 1'b0;
    end else if (wreq.addr == dsg_pkg::DSG_SLP_OFF) begin
      werr = 1'b0;
    end else if (wreq.addr == dsg_pkg::DSG_DEEP_OFF) begin
      werr = 1'b0;
    end else if (wreq.addr == dsg_pkg::DSG_RCFG_OFF) begin
      werr = 1'b0;
    end else if (wreq.addr == dsg_pkg::DSG_ISTAT_OFF) begin
      werr = 1'b0;
    end else if (wreq.addr == dsg_pkg::DSG_IMASK_OFF) begin
      werr = 1'b0;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.grant = 1'b0;
    next_s.fault = 1'b0;
    if (wreq.valid) begin
      // Masking keeps reserved bits of the gate registers at zero whatever is written
      if (wreq.addr == dsg_pkg::DSG_RUN_OFF) begin
        next_s.run_gates = lane_merge(s.run_gates, wreq.data,
          wreq.strb) & dsg_pkg::DSG_GATE_WMASK;
      end else if (wreq.addr == dsg_pkg::DSG_SLP_OFF) begin
        next_s.sleep_gates = lane_merge(s.sleep_gates, wreq.data,
          wreq.strb) & dsg_pkg::DSG_GATE_WMASK;
      end else if (wreq.addr == dsg_pkg::DSG_DEEP_OFF) begin
        next_s.deep_gates = lane_merge(s.deep_gates, wreq.data,
          wreq.strb) & dsg_pkg::DSG_GATE_WMASK;
      end else if (wreq.addr == dsg_pkg::DSG_RCFG_OFF) begin
        next_s.rcfg = lane_merge(s.rcfg, wreq.data, wreq.strb);
      end else if (wreq.addr == dsg_pkg::DSG_ISTAT_OFF) begin
        if (wreq.strb[0]) begin
          next_s.istat = s.istat & ~wreq.data[dsg_pkg::DSG_IRQ_W-1:0];
        end
      end else if (wreq.addr == dsg_pkg::DSG_IMASK_OFF) begin
        if (wreq.strb[0]) begin
          next_s.imask = wreq.data[dsg_pkg::DSG_IRQ_W-1:0];
        end
      end
    end
    // Deep sleep outranks sleep when both are asserted
    if (deep_sleep_now) begin
      next_s.mode = dsg_pkg::DSG_DEEP;
    end else if (sleep_now) begin
      next_s.mode = dsg_pkg::DSG_SLEEP;
    end else begin
      next_s.mode = dsg_pkg::DSG_RUN;
    end
    if (next_s.mode == dsg_pkg::DSG_DEEP && s.mode != dsg_pkg::DSG_DEEP) begin
      next_s.istat[dsg_pkg::DSG_IRQ_DEEP] = 1'b1;
    end
    // Judged against the enables that are live this cycle
    if (unit_req) begin
      if (en_now[unit_sel]) begin
        next_s.grant = 1'b1;
      end else begin
        next_s.fault = 1'b1;
        next_s.istat[dsg_pkg::DSG_IRQ_FAULT] = 1'b1;
      end
    end
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.run_gates <= dsg_pkg::DSG_GATE_RST;
      s.sleep_gates <= dsg_pkg::DSG_GATE_RST;
      s.deep_gates <= dsg_pkg::DSG_GATE_RST;
      s.rcfg <= dsg_pkg::DSG_RCFG_RST;
      s.mode <= dsg_pkg::DSG_RUN;
    end else begin
      s <= next_s;
    end
  end

  assign unit_grant = s.grant;
  assign unit_fault = s.fault;
  assign unit_clk_en = en_now;
  assign irq = s.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_clears_gates_a: assert property (disable iff (1'b0)
    !aresetn |=> s.deep_gates == 32'h0000_0000 && unit_clk_en == '0)
    else $error("gates not clear after reset");

  gated_access_fault_a: assert property (
    unit_req && !unit_clk_en[unit_sel] |=> unit_fault && !unit_grant)
    else $error("access to gated unit not faulted");

  open_access_grant_a: assert property (
    unit_req && unit_clk_en[unit_sel] |=> unit_grant && !unit_fault)
    else $error("access to clocked unit not granted");

  deep_set_applies_a: assert property (
    s.mode == dsg_pkg::DSG_DEEP && auto_clock_gating_select |=> unit_clk_en == $past(deep_vec))
    else $error("deep set not applied in deep sleep");

  sleep_set_applies_a: assert property (
    s.mode == dsg_pkg::DSG_SLEEP && auto_clock_gating_select |=> unit_clk_en == $past(sleep_vec))
    else $error("sleep set not applied in sleep");

  acg_off_inert_a: assert property (
    !auto_clock_gating_select |=> unit_clk_en == $past(run_vec))
    else $error("sleep sets acted without auto gating");

  reserved_zero_a: assert property (
    ((s.run_gates | s.sleep_gates | s.deep_gates) &
      ~dsg_pkg::DSG_GATE_WMASK) == 32'h0000_0000)
    else $error("reserved gate bit set");

  deep_write_map_a: assert property (
    wreq.valid && wreq.addr == dsg_pkg::DSG_DEEP_OFF && wreq.strb == 4'hf
    |=> s.deep_gates == ($past(wreq.data) & dsg_pkg::DSG_GATE_WMASK)
    ##0 deep_vec == {s.deep_gates[18], s.deep_gates[17], s.deep_gates[16],
    s.deep_gates[14], s.deep_gates[12], s.deep_gates[5], s.deep_gates[4],
    s.deep_gates[0]})
    else $error("deep gate write mismatch");

  fault_sticky_a: assert property (
    unit_fault |-> s.istat[dsg_pkg::DSG_IRQ_FAULT])
    else $error("fault did not set status");

  irq_level_a: assert property (
    irq == |(s.istat & s.imask))
    else $error("interrupt level mismatch");

  deep_cover_c: cover property (
    s.mode == dsg_pkg::DSG_DEEP && auto_clock_gating_select && |unit_clk_en);
  fault_cover_c: cover property (unit_fault ##1 irq);
  grant_cover_c: cover property (unit_grant);
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the deep-sleep clock gating block
// Assumes: Bench drives every port; AXI4-Lite master modelled by tasks
// Notes: Random data from a fixed seed, corner values mixed in
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sleep_now, deep_sleep_now, unit_req, unit_grant, unit_fault, irq;
  logic [2:0] unit_sel;
  logic [7:0] unit_clk_en;
  int n_errors, compares, seed, u;
  logic [31:0] rd, run_g, slp_g, dp_g;
  logic [1:0] rsp;
  // Bit positions of the eight unit gates, unit order of unit_clk_en
  int pos [8] = '{0, 4, 5, 12, 14, 16, 17, 18};

  dsg_top u_dsg_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sleep_now(sleep_now),
    .deep_sleep_now(deep_sleep_now), .unit_req(unit_req),
    .unit_sel(unit_sel), .unit_grant(unit_grant),
    .unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================
  // Expectations
  function automatic logic [31:0] wmask_f();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 8; i++) m[pos[i]] = 1'b1;
    return m;
  endfunction

  function automatic logic [7:0] en_of(input logic [31:0] g);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) e[i] = g[pos[i]];
    return e;
  endfunction

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end

  // ==========================================================
  // Bus master: hold each channel until its own ready
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && t < 100);
    if (t >= 100) n_errors++;
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && t < 100);
    if (t >= 100) n_errors++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Enables lag a register or mode change by one edge
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // One access; grant or fault pulses one cycle later
  task automatic uacc(input int s, input logic exp_grant);
    @(posedge aclk);
    unit_req <= 1'b1;
    unit_sel <= 3'(s);
    @(posedge aclk);
    unit_req <= 1'b0;
    #1;
    chk(32'(unit_grant), 32'(exp_grant));
    chk(32'(unit_fault), 32'(!exp_grant));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 63;
    n_errors = 0;
    compares = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h0;
    {sleep_now, deep_sleep_now, unit_req} = '0;
    unit_sel = 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;

    axr(12'h124, rd, rsp);
    chk(rd, 32'h0000_0000);
    chk(32'(unit_clk_en), 32'h0000_0000);
    $display("test reset done");

    // Gates inert while auto gating is off and run set is clear
    for (int i = 0; i < 18; i++) begin
      dp_g = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      axw(12'h124, dp_g, rsp);
      axr(12'h124, rd, rsp);
      chk(rd, dp_g & wmask_f());
      chk(32'(rsp), 32'(2'h0));
      chk(32'(unit_clk_en), 32'h0000_0000);
    end
    $display("test fields done");

    axw(12'h060, 32'h0800_0000, rsp);
    deep_sleep_now <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      axw(12'h124, 32'h1 << pos[i], rsp);
      settle();
      chk(32'(unit_clk_en), 32'h1 << i);
      uacc(i, 1'b1);
      uacc((i + 1) % 8, 1'b0);
    end
    $display("test units done");

    for (int k = 0; k < 6; k++) begin
      run_g = $random(seed);
      slp_g = $random(seed);
      dp_g = $random(seed);
      axw(12'h104, run_g, rsp);
      axw(12'h114, slp_g, rsp);
      axw(12'h124, dp_g, rsp);
      axw(12'h060, 32'h0800_0000, rsp);
      sleep_now <= 1'b1;
      deep_sleep_now <= 1'b1;
      settle();
      chk(32'(unit_clk_en), 32'(en_of(dp_g)));
      u = $unsigned($random(seed)) % 8;
      uacc(u, dp_g[pos[u]]);
      deep_sleep_now <= 1'b0;
      settle();
      chk(32'(unit_clk_en), 32'(en_of(slp_g)));
      sleep_now <= 1'b0;
      settle();
      chk(32'(unit_clk_en), 32'(en_of(run_g)));
      deep_sleep_now <= 1'b1;
      axw(12'h060, 32'h0000_0000, rsp);
      settle();
      chk(32'(unit_clk_en), 32'(en_of(run_g)));
      deep_sleep_now <= 1'b0;
      settle();
    end
    $display("test modes done");

    // Interrupts and bus errors; auto gating is off here
    axw(12'h204, 32'h0000_0003, rsp);
    chk(32'(rsp), 32'(2'h0));
    axw(12'h200, 32'h0000_0003, rsp);
    axw(12'h104, 32'h0000_0000, rsp);
    settle();
    chk(32'(irq), 32'h0000_0000);
    uacc(0, 1'b0);
    chk(32'(irq), 32'h0000_0001);
    axr(12'h200, rd, rsp);
    chk(rd, 32'h0000_0001);
    axw(12'h208, 32'h0000_0000, rsp);
    chk(32'(rsp), 32'(2'h2));
    axr(12'h300, rd, rsp);
    chk(32'(rsp), 32'(2'h2));
    chk(rd, 32'h0000_0000);
    axw(12'h200, 32'h0000_0001, rsp);
    settle();
    chk(32'(irq), 32'h0000_0000);
    $display("test interrupts done");

    // Reset again in mid-run with gates set
    axw(12'h124, 32'hffff_ffff, rsp);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h124, rd, rsp);
    chk(rd, 32'h0000_0000);
    chk(32'(unit_clk_en), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    $display("test second reset done");
    results();
  end
endmodule
